// ---- common/sentfp_pkg.sv ----
`default_nettype none
package sentfp_pkg;
	// transmission_method_select encodings
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_STREAM = 3'h1;
	localparam logic [2:0] MODE_SYNC = 3'h2;
	localparam logic [2:0] MODE_TRIG_SCN = 3'h3;
	localparam logic [2:0] MODE_TRIG_FALL = 3'h4;
	localparam logic [2:0] MODE_ADDR = 3'h5;
	localparam logic [2:0] MODE_SEQ = 3'h6;
	localparam logic [2:0] MODE_LSEQ = 3'h7;
	// widths
	localparam int ANGLE_W = 12;
	localparam int LEN_W = 8;
	localparam int PAUSE_W = 10;
	// pulse lengths in ticks
	localparam logic [LEN_W-1:0] SENT_LOW_TICKS = 8'h05;
	localparam logic [LEN_W-1:0] OUT_MIN = 8'h0F;
	localparam logic [LEN_W-1:0] OUT_MAX = 8'h13;
	localparam logic [LEN_W-1:0] SAMPLE_MIN = 8'h1F;
	localparam logic [LEN_W-1:0] SAMPLE_MAX = 8'h27;
	localparam logic [LEN_W-1:0] DIAG_MIN = 8'h38;
	localparam logic [LEN_W-1:0] DIAG_MAX = 8'h46;
	localparam logic [LEN_W-1:0] SYNC_MIN = 8'h5D;
	localparam logic [LEN_W-1:0] SYNC_MAX = 8'h73;
	localparam logic [LEN_W-1:0] LOUT_MIN = 8'h09;
	localparam logic [LEN_W-1:0] LOUT_MAX = 8'h51;
	localparam logic [LEN_W-1:0] LSYNC_MIN = 8'h69;
	localparam logic [LEN_W-1:0] LSYNC_MAX = 8'hAB;
	localparam logic [LEN_W-1:0] TRIG_DELAY_TICKS = 8'h07;
	localparam logic [PAUSE_W-1:0] PAUSE_MIN_TICKS = 10'h00C;
	localparam logic [PAUSE_W-1:0] PAUSE_MAX_TICKS = 10'h300;
	localparam logic [1:0] UPD_CAPTURE_TICKS = 2'h2;
	// ids that allow serial programming
	localparam logic [1:0] PROG_ID_A = 2'h0;
	localparam logic [1:0] PROG_ID_B = 2'h2;
	// frame start request to the encoder
	typedef struct packed {
		logic sample_at_scn;
		logic [ANGLE_W-1:0] angle;
	} sentfp_req_t;
	// decoded function pulse events
	typedef struct packed {
		logic sample;
		logic diag;
		logic sync;
	} sentfp_fn_t;
	localparam int REQ_W = $bits(sentfp_req_t);
endpackage : sentfp_pkg
`default_nettype wire

// ---- logic/sentfp_buf2.sv ----
`timescale 1ns/1ps
`default_nettype none
module sentfp_buf2 #(
	parameter int W = 13
) (
	input wire logic clk, // clock
	input wire logic rst, // async reset
	input wire logic in_valid, // write request
	output logic in_ready, // space free
	input wire logic [W-1:0] in_data, // write word
	output logic out_valid, // head valid
	input wire logic out_ready, // reader takes head
	output logic [W-1:0] out_data // head word
);
	// elaboration check of the width
	if (W < 1) begin : g_bad_w
		$error("sentfp_buf2: W must be positive");
	end

	logic v0_r, v1_r;
	logic [W-1:0] d0_r, d1_r;
	wire push = in_valid & ~v1_r;
	wire pop = v0_r & out_ready;

	assign in_ready = ~v1_r;
	assign out_valid = v0_r;
	assign out_data = d0_r;

	// head entry: shifts from tail on pop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			v0_r <= 1'b0;
			d0_r <= '0;
		end else if (pop) begin
			v0_r <= v1_r | push;
			d0_r <= v1_r ? d1_r : in_data;
		end else if (push & ~v0_r) begin
			v0_r <= 1'b1;
			d0_r <= in_data;
		end
	end

	// tail entry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			v1_r <= 1'b0;
			d1_r <= '0;
		end else if (pop) begin
			v1_r <= v1_r & push;
			d1_r <= in_data;
		end else if (push & v0_r) begin
			v1_r <= 1'b1;
			d1_r <= in_data;
		end
	end
endmodule : sentfp_buf2
`default_nettype wire

// ---- logic/sentfp_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: three-bit select; 000 disables output
// RQ2: 001 streams frames back to back
// RQ3: stream samples angle at status nibble end
// RQ4: 010 waits pause until fresh angle
// RQ5: 010 captures angle 1-2 ticks after update
// RQ6: pause at least 12, restarts at 768
// RQ7: trigger release then 7 ticks, frame
// RQ8: 011 latches angle at status nibble end
// RQ9: 100 latches angle at host falling edge
// RQ10: trigger needs minimum low time, continuous pause
// RQ11: 101/110/111 select the shared modes
// RQ12: line only driven low, else released
// RQ13: sensor id from two select pins
// RQ14: programming only with id 0 or 2
// RQ15: host low pulses measured in ticks
// RQ16: broadcast for all, addressing for match
// RQ17: unimplemented function pulse does nothing
// RQ18: host pulses longer than 5 ticks
// RQ19: pulse lengths judged in tick units
// RQ20: addressable ranges 15-19, 31-39, 56-70
// RQ21: sync pulse 93-115 resets slot counter
// RQ22: idle pause while no host request
// RQ23: out-of-range pulses are ignored
// RQ24: own frame edges are not measured
module sentfp_ctrl
	import sentfp_pkg::*;
#(
	parameter int MIN_TRIG_TICKS = 2
) (
	input wire logic clk, // 25 MHz clock
	input wire logic rst, // async reset, high
	input wire logic [2:0] transmission_method_select, // nonvolatile mode field
	input wire logic [7:0] tick_div, // clocks per tick minus one
	input wire logic [ANGLE_W-1:0] angle_in, // current angle
	input wire logic angle_update, // internal update pulse
	input wire logic line_in, // sent line level, pin
	output logic line_oe, // high: pull line low
	output logic line_out, // driven level, always low
	input wire logic id_select_pin_low, // id pin bit 0
	input wire logic id_select_pin_high, // id pin bit 1
	input wire logic [1:0] slot_number, // current slot from slot logic
	input wire logic tx_low, // encoder wants line low
	input wire logic frame_busy, // encoder sending a frame
	input wire logic scn_end, // end of status_comm_nibble pulse
	output logic frame_valid, // frame start request valid
	input wire logic frame_ready, // encoder takes request
	output sentfp_req_t frame_req, // request word
	output logic [ANGLE_W-1:0] angle_tx, // angle the frame carries
	output logic pause_restart, // pause pulse restart pulse
	output sentfp_fn_t fn_event, // decoded function pulses
	output logic [1:0] sensor_id, // decoded id
	output logic prog_enable, // serial programming allowed
	output logic sent_enable // output enabled
);
	// elaboration check of the trigger length
	if (MIN_TRIG_TICKS < 1 || MIN_TRIG_TICKS > 255) begin : g_bad_trig
		$error("sentfp_ctrl: MIN_TRIG_TICKS out of range");
	end

	localparam logic [LEN_W-1:0] MIN_TRIG = LEN_W'(MIN_TRIG_TICKS);

	typedef enum logic [1:0] {TR_IDLE, TR_LOW, TR_DELAY} sentfp_trig_t;

	function automatic logic in_rng(input logic [LEN_W-1:0] v, input logic [LEN_W-1:0] lo,
		input logic [LEN_W-1:0] hi);
		in_rng = (v >= lo) && (v <= hi);
	endfunction : in_rng

	logic [7:0] div_r;
	logic tick_r;
	logic line_meta_r, line_s_r, line_prev_r;
	logic [1:0] id_meta_r, id_s_r;
	logic [2:0] own_hist_r;
	logic meas_r;
	logic [LEN_W-1:0] len_r;
	sentfp_trig_t trig_r;
	logic [LEN_W-1:0] dly_r;
	logic pend_r;
	sentfp_req_t pend_data_r;
	logic [ANGLE_W-1:0] hold_r, sync_angle_r, angle_tx_r;
	logic hold_v_r, fresh_r, upd_wait_r, cur_scn_r;
	logic [1:0] upd_ph_r;
	logic [PAUSE_W-1:0] pause_r;
	logic pause_restart_r, line_oe_r, prog_r, en_r;
	logic [1:0] sensor_id_r;
	sentfp_fn_t fn_r;
	logic buf_ready;

	// mode decode
	wire [2:0] mode = transmission_method_select;
	// mode 000 turns off line drive, frame launches and sent_enable; id and prog decode still run
	// RQ1: disable decode
	wire enabled = (mode != MODE_OFF);
	wire m_trig = (mode == MODE_TRIG_SCN) | (mode == MODE_TRIG_FALL);
	// RQ11: shared mode decode
	wire m_shared = (mode == MODE_ADDR) | (mode == MODE_SEQ) | (mode == MODE_LSEQ);

	// host low detection, own traffic masked
	// RQ24: mask own drive
	wire own_mask = frame_busy | line_oe_r | (|own_hist_r);
	wire host_low = ~line_s_r & ~own_mask;
	wire host_fall = host_low & line_prev_r & ~meas_r;
	wire host_rise = meas_r & line_s_r;

	// function pulse decode by length
	// RQ20: addressable ranges
	wire r_out = (mode == MODE_LSEQ) ? in_rng(len_r, LOUT_MIN, LOUT_MAX) & ~in_rng(len_r, DIAG_MIN, DIAG_MAX)
		: in_rng(len_r, OUT_MIN, OUT_MAX);
	wire r_samp = ((mode == MODE_ADDR) | (mode == MODE_SEQ)) & in_rng(len_r, SAMPLE_MIN, SAMPLE_MAX);
	wire r_diag = in_rng(len_r, DIAG_MIN, DIAG_MAX);
	// RQ21: sync only in sequential modes
	wire r_sync = ((mode == MODE_SEQ) & in_rng(len_r, SYNC_MIN, SYNC_MAX))
		| ((mode == MODE_LSEQ) & in_rng(len_r, LSYNC_MIN, LSYNC_MAX));
	// RQ18: shorter than frame low part is traffic
	wire fn_take = host_rise & m_shared & (len_r > SENT_LOW_TICKS);
	// RQ16: addressing needs id match
	wire addressed = (slot_number == sensor_id_r);
	// RQ17: unsupported functions yield no event
	// RQ23: out of every range yields nothing
	wire fn_out_req = fn_take & r_out & addressed;

	// launch sources
	wire q_idle = ~pend_r & ~frame_valid & ~frame_busy;
	// RQ2: back to back streaming
	wire go_stream = (mode == MODE_STREAM) & q_idle;
	// RQ4: wait for fresh angle
	// RQ6: minimum pause before frame
	wire go_sync = (mode == MODE_SYNC) & q_idle & fresh_r & (pause_r >= PAUSE_MIN_TICKS);
	wire go_trig = (trig_r == TR_DELAY) & tick_r & (dly_r == TRIG_DELAY_TICKS - 8'h01);
	wire launch = enabled & (go_stream | go_sync | go_trig | fn_out_req);
	wire [ANGLE_W-1:0] shared_angle = hold_v_r ? hold_r : angle_in;
	sentfp_req_t new_req;
	assign new_req.sample_at_scn = go_stream | (go_trig & (mode == MODE_TRIG_SCN));
	assign new_req.angle = go_sync ? sync_angle_r : (mode == MODE_TRIG_FALL) ? hold_r : shared_angle;

	// tick divider
	// RQ19: all lengths counted in ticks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == 8'h00);
			div_r <= (div_r == 8'h00) ? tick_div : div_r - 8'h01;
		end
	end

	// pin synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_meta_r <= 1'b1;
			line_s_r <= 1'b1;
			line_prev_r <= 1'b1;
			id_meta_r <= 2'h0;
			id_s_r <= 2'h0;
		end else begin
			line_meta_r <= line_in;
			line_s_r <= line_meta_r;
			line_prev_r <= line_s_r;
			id_meta_r <= {id_select_pin_high, id_select_pin_low};
			id_s_r <= id_meta_r;
		end
	end

	// id and programming permission
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sensor_id_r <= 2'h0;
			prog_r <= 1'b0;
			en_r <= 1'b0;
		end else begin
			// RQ13: id from pins
			sensor_id_r <= id_s_r;
			// RQ14: only ids 0 and 2
			prog_r <= (id_s_r == PROG_ID_A) | (id_s_r == PROG_ID_B);
			en_r <= enabled;
		end
	end

	// open-drain drive, own history for masking
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_oe_r <= 1'b0;
			own_hist_r <= 3'h0;
		end else begin
			// RQ12: low only, else released
			// RQ22: idle pause leaves line released
			line_oe_r <= enabled & frame_busy & tx_low;
			own_hist_r <= {own_hist_r[1:0], line_oe_r | frame_busy};
		end
	end

	// host low pulse length measurement
	// RQ15: length in ticks, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meas_r <= 1'b0;
			len_r <= '0;
		end else if (host_fall) begin
			meas_r <= 1'b1;
			len_r <= '0;
		end else if (host_rise) begin
			meas_r <= 1'b0;
		end else if (meas_r & tick_r & (len_r != 8'hFF)) begin
			len_r <= len_r + 8'h01;
		end
	end

	// trigger sequencer for modes 011 and 100
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trig_r <= TR_IDLE;
			dly_r <= '0;
		end else begin
			unique case (trig_r)
				TR_IDLE: begin
					if (m_trig & host_fall & q_idle) trig_r <= TR_LOW;
				end
				TR_LOW: begin
					// RQ10: minimum trigger low time
					if (host_rise) trig_r <= (len_r >= MIN_TRIG) ? TR_DELAY : TR_IDLE;
					dly_r <= '0;
				end
				TR_DELAY: begin
					// RQ7: release delay count
					if (go_trig | ~m_trig) trig_r <= TR_IDLE;
					else if (tick_r) dly_r <= dly_r + 8'h01;
				end
			endcase
		end
	end

	// held angle for falling-edge and sample functions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_r <= '0;
			hold_v_r <= 1'b0;
		end else if ((mode == MODE_TRIG_FALL) & host_fall) begin
			// RQ9: latch at host falling edge
			hold_r <= angle_in;
		end else if (fn_take & r_samp) begin
			hold_r <= angle_in;
			hold_v_r <= 1'b1;
		end else if (fn_out_req & launch) begin
			hold_v_r <= 1'b0;
		end
	end

	// update capture for mode 010
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			upd_wait_r <= 1'b0;
			upd_ph_r <= 2'h0;
			sync_angle_r <= '0;
			fresh_r <= 1'b0;
		end else begin
			if (angle_update) begin
				upd_wait_r <= 1'b1;
				upd_ph_r <= 2'h0;
			end else if (upd_wait_r & tick_r) begin
				// RQ5: capture on second tick edge
				if (upd_ph_r == UPD_CAPTURE_TICKS - 2'h1) begin
					upd_wait_r <= 1'b0;
					sync_angle_r <= angle_in;
				end
				upd_ph_r <= upd_ph_r + 2'h1;
			end
			// capture wins over consumption
			if (upd_wait_r & tick_r & (upd_ph_r == UPD_CAPTURE_TICKS - 2'h1)) fresh_r <= 1'b1;
			else if (go_sync & buf_ready) fresh_r <= 1'b0;
		end
	end

	// pause length counter for mode 010
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pause_r <= '0;
			pause_restart_r <= 1'b0;
		end else begin
			pause_restart_r <= 1'b0;
			if (frame_busy | (mode != MODE_SYNC) | launch) begin
				pause_r <= '0;
			end else if (tick_r) begin
				// RQ6: restart after 768 ticks
				if (pause_r == PAUSE_MAX_TICKS - 10'h001) begin
					pause_r <= '0;
					pause_restart_r <= 1'b1;
				end else begin
					pause_r <= pause_r + 10'h001;
				end
			end
		end
	end

	// pending request waits for buffer space
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_r <= 1'b0;
			pend_data_r <= '0;
		end else if (launch) begin
			pend_r <= 1'b1;
			pend_data_r <= new_req;
		end else if (buf_ready) begin
			pend_r <= 1'b0;
		end
	end

	// two-entry buffer toward the encoder
	sentfp_buf2 #(
		.W(REQ_W)
	) u_buf (
		.clk(clk),
		.rst(rst),
		.in_valid(pend_r),
		.in_ready(buf_ready),
		.in_data(pend_data_r),
		.out_valid(frame_valid),
		.out_ready(frame_ready),
		.out_data(frame_req)
	);

	// angle carried by the running frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			angle_tx_r <= '0;
			cur_scn_r <= 1'b0;
		end else if (frame_valid & frame_ready) begin
			angle_tx_r <= frame_req.angle;
			cur_scn_r <= frame_req.sample_at_scn;
		end else if (scn_end & cur_scn_r) begin
			// RQ3: stream sample at nibble end
			// RQ8: trigger latch at nibble end
			angle_tx_r <= angle_in;
		end
	end

	// function pulse event strobes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fn_r <= '0;
		end else begin
			fn_r.sample <= fn_take & r_samp;
			fn_r.diag <= fn_take & r_diag & ~r_out;
			fn_r.sync <= fn_take & r_sync;
		end
	end

	assign line_oe = line_oe_r;
	assign line_out = 1'b0;
	assign angle_tx = angle_tx_r;
	assign pause_restart = pause_restart_r;
	assign fn_event = fn_r;
	assign sensor_id = sensor_id_r;
	assign prog_enable = prog_r;
	assign sent_enable = en_r;
endmodule : sentfp_ctrl
`default_nettype wire

// ---- sim/sentfp_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sentfp_ctrl_props
	import sentfp_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst, // async reset
	input wire logic [2:0] transmission_method_select, // mode field
	input wire logic tx_low, // encoder low request
	input wire logic frame_busy, // encoder busy
	input wire logic frame_ready, // encoder takes request
	input wire logic line_oe, // device pulls low
	input wire logic line_out, // driven level
	input wire logic frame_valid, // request valid
	input wire sentfp_req_t frame_req, // request word
	input wire logic pause_restart, // pause wrap pulse
	input wire sentfp_fn_t fn_event, // function pulses
	input wire logic [1:0] sensor_id, // decoded id
	input wire logic prog_enable, // programming allowed
	input wire logic sent_enable // output on
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// short alias for the mode field
	wire [2:0] m = transmission_method_select;
	low_only_a: assert property (line_out == 1'b0) else $error("line driven high");
	oe_cause_a: assert property (line_oe == $past(tx_low && frame_busy && m != MODE_OFF))
		else $error("line pull without frame");
	en_mode_a: assert property ($stable(m) |=> sent_enable == (m != MODE_OFF)) else $error("enable vs mode");
	prog_id_a: assert property ($stable(sensor_id) && sensor_id[0] |-> !prog_enable)
		else $error("programming on odd id");
	fn_mode_a: assert property (fn_event != 3'h0 |-> m >= MODE_ADDR) else $error("function in wrong mode");
	sync_mode_a: assert property (fn_event.sync |-> m == MODE_SEQ || m == MODE_LSEQ)
		else $error("sync in wrong mode");
	sample_mode_a: assert property (fn_event.sample |-> m == MODE_ADDR || m == MODE_SEQ)
		else $error("sample in wrong mode");
	fn_single_a: assert property (fn_event != 3'h0 |=> fn_event == 3'h0) else $error("function pulse too long");
	own_edge_a: assert property (frame_busy [*4] |-> fn_event == 3'h0) else $error("own frame decoded");
	req_hold_a: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_req))
		else $error("request dropped");
	pause_wrap_a: assert property (pause_restart |-> m == MODE_SYNC ##1 !pause_restart)
		else $error("pause restart wrong");
endmodule : sentfp_ctrl_props
bind sentfp_ctrl sentfp_ctrl_props props (.clk(clk), .rst(rst),
	.transmission_method_select(transmission_method_select), .tx_low(tx_low), .frame_busy(frame_busy),
	.frame_ready(frame_ready), .line_oe(line_oe), .line_out(line_out), .frame_valid(frame_valid),
	.frame_req(frame_req), .pause_restart(pause_restart), .fn_event(fn_event),
	.sensor_id(sensor_id), .prog_enable(prog_enable), .sent_enable(sent_enable));
`default_nettype wire

// ---- sim/sentfp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sentfp_host (
	input wire logic clk, // bench clock
	input wire logic dut_oe, // device pulls low
	input wire logic [7:0] tick_div, // clocks per tick minus one
	output logic line // wired line level
);
	logic host_low = 1'b0;
	assign line = !(host_low || dut_oe);
	task automatic pulse(input int ticks);
		@(posedge clk);
		#1 host_low = 1'b1;
		repeat (ticks * (int'(tick_div) + 1)) @(posedge clk);
		#1 host_low = 1'b0;
	endtask : pulse
endmodule : sentfp_host
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top import sentfp_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, upd = 1'b0, id_lo = 1'b0, id_hi = 1'b0, busy = 1'b0, txl = 1'b0;
	logic status_comm_nibble = 1'b0, rdy = 1'b1, line, oe, lout, fv, pr, sen, pen;
	logic [2:0] mode = 3'h0;
	logic [1:0] slot = 2'h0, sid;
	logic [ANGLE_W-1:0] ang = 12'h000, atx;
	logic [7:0] tdiv = 8'h03;
	sentfp_req_t req;
	sentfp_fn_t fn, fn_seen = 3'h0;
	int n_errors = 0, n_checks = 0, n_req = 0, n_pr = 0, cnt;
	sentfp_ctrl #(.MIN_TRIG_TICKS(2)) dut (.clk(clk), .rst(rst), .transmission_method_select(mode),
		.tick_div(tdiv), .angle_in(ang), .angle_update(upd), .line_in(line), .line_oe(oe), .line_out(lout),
		.id_select_pin_low(id_lo), .id_select_pin_high(id_hi), .slot_number(slot), .tx_low(txl), .frame_busy(busy),
		.scn_end(status_comm_nibble), .frame_valid(fv), .frame_ready(rdy), .frame_req(req), .angle_tx(atx), .pause_restart(pr),
		.fn_event(fn), .sensor_id(sid), .prog_enable(pen), .sent_enable(sen));
	sentfp_host host (.clk(clk), .dut_oe(oe), .tick_div(tdiv), .line(line));
	always #20 clk = ~clk;
	// collect one-cycle events
	always @(posedge clk) begin
		fn_seen <= fn_seen | fn;
		if (fv && rdy) n_req <= n_req + 1;
		if (pr) n_pr <= n_pr + 1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic restart(input logic [2:0] m, input logic [1:0] id);
		rst = 1'b1;
		mode = m;
		{id_hi, id_lo} = id;
		slot = id;
		cyc(6);
		rst = 1'b0;
		cyc(4);
	endtask : restart
	// host pulse, then decoded events and frame requests
	task automatic hp(input int ticks, input sentfp_fn_t e_fn, input int e_req);
		fn_seen = 3'h0;
		n_req = 0;
		host.pulse(ticks);
		cyc(8);
		`CHK(fn_seen, e_fn)
		`CHK(n_req, e_req)
	endtask : hp
	task automatic wait_pr(input int k);
		cnt = 0;
		while (n_pr < k && cnt < 4000) begin
			cyc(1);
			cnt++;
		end
	endtask : wait_pr
	task automatic t_ids;
		for (int i = 0; i < 4; i++) begin
			restart(MODE_ADDR, i[1:0]);
			`CHK(sid, i[1:0])
			`CHK(pen, i[1:0] == PROG_ID_A || i[1:0] == PROG_ID_B)
		end
		$display("ids test done");
	endtask : t_ids
	task automatic t_off;
		restart(MODE_OFF, 2'h1);
		{busy, txl} = 2'h3;
		cyc(3);
		`CHK(oe, 1'b0)
		`CHK(sen, 1'b0)
		{busy, txl} = 2'h0;
		hp(17, 3'h0, 0);
		restart(MODE_STREAM, 2'h1);
		{busy, txl} = 2'h3;
		cyc(3);
		`CHK(line, 1'b0)
		`CHK(sen, 1'b1)
		txl = 1'b0;
		cyc(3);
		`CHK(line, 1'b1)
		busy = 1'b0;
		$display("off test done");
	endtask : t_off
	task automatic t_addr;
		restart(MODE_ADDR, 2'h1);
		hp(17, 3'h0, 1);
		// own frame low of output length must not decode
		fn_seen = 3'h0;
		{busy, txl} = 2'h3;
		cyc(68);
		{busy, txl} = 2'h0;
		cyc(8);
		`CHK(fn_seen, 3'h0)
		hp(63, 3'h2, 0);
		hp(25, 3'h0, 0);
		hp(4, 3'h0, 0);
		hp(104, 3'h0, 0);
		slot = 2'h2;
		hp(17, 3'h0, 0);
		ang = 12'h6A9;
		hp(35, 3'h4, 0);
		slot = 2'h1;
		ang = 12'h123;
		hp(17, 3'h0, 1);
		`CHK(atx, 12'h6A9)
		$display("addressable test done");
	endtask : t_addr
	task automatic t_seq;
		restart(MODE_SEQ, 2'h0);
		hp(104, 3'h1, 0);
		hp(35, 3'h4, 0);
		hp(17, 3'h0, 1);
		tdiv = 8'h01;
		restart(MODE_LSEQ, 2'h0);
		hp(140, 3'h1, 0);
		hp(95, 3'h0, 0);
		hp(40, 3'h0, 1);
		hp(63, 3'h2, 0);
		tdiv = 8'h03;
		$display("sequential test done");
	endtask : t_seq
	task automatic t_trig(input logic [2:0] m);
		restart(m, 2'h0);
		rdy = 1'b0;
		ang = 12'hA5C;
		// too short a trigger is refused
		host.pulse(1);
		cyc(40);
		`CHK(fv, 1'b0)
		fork
			host.pulse(4);
			begin
				cyc(6);
				ang = 12'h3B1;
			end
		join
		`CHK(fv, 1'b0)
		cnt = 0;
		while (fv !== 1'b1 && cnt < 100) begin
			cyc(1);
			cnt++;
		end
		`CHK(cnt >= 26 && cnt <= 36, 1'b1)
		`CHK(req.sample_at_scn, m == MODE_TRIG_SCN)
		rdy = 1'b1;
		cyc(1);
		ang = 12'h777;
		status_comm_nibble = 1'b1;
		cyc(1);
		status_comm_nibble = 1'b0;
		cyc(1);
		`CHK(atx, m == MODE_TRIG_SCN ? 12'h777 : 12'hA5C)
		$display("trigger test done");
	endtask : t_trig
	task automatic t_stream;
		restart(MODE_STREAM, 2'h0);
		ang = 12'h5E1;
		n_req = 0;
		cyc(40);
		`CHK(n_req > 3, 1'b1)
		`CHK(req.sample_at_scn, 1'b1)
		rdy = 1'b0;
		cyc(3);
		`CHK(atx, 12'h5E1)
		ang = 12'h1E5;
		status_comm_nibble = 1'b1;
		cyc(1);
		status_comm_nibble = 1'b0;
		cyc(1);
		`CHK(atx, 12'h1E5)
		rdy = 1'b1;
		$display("stream test done");
	endtask : t_stream
	task automatic t_sync;
		restart(MODE_SYNC, 2'h0);
		n_req = 0;
		cyc(100);
		`CHK(n_req, 0)
		ang = 12'h2D4;
		upd = 1'b1;
		cyc(1);
		upd = 1'b0;
		cyc(9);
		ang = 12'h0F0;
		cyc(20);
		`CHK(n_req, 1)
		`CHK(atx, 12'h2D4)
		// fresh angle soon after a frame waits for the minimum pause
		upd = 1'b1;
		cyc(1);
		upd = 1'b0;
		n_req = 0;
		cyc(12);
		`CHK(n_req, 0)
		cyc(30);
		`CHK(n_req, 1)
		n_pr = 0;
		wait_pr(1);
		wait_pr(2);
		`CHK(cnt, int'(PAUSE_MAX_TICKS) * (int'(tdiv) + 1))
		$display("sync test done");
	endtask : t_sync
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		t_ids;
		t_off;
		t_addr;
		t_seq;
		t_trig(MODE_TRIG_SCN);
		t_trig(MODE_TRIG_FALL);
		t_stream;
		t_sync;
		give_verdict;
	end
	// watchdog against a hang
	initial begin
		#2000000;
		n_errors++;
		give_verdict;
	end
endmodule : tb_top
`default_nettype wire
